// file: dv/tat_alert_thermal_shutdown_out_tb.sv
// Self-checking bench for the alert and thermal shutdown logic.
`timescale 1ns/10ps
`default_nettype none
module tat_alert_thermal_shutdown_out_tb
   import tat_pkg::*;
;
   localparam logic [6:0] ADDR = 7'h33;  // Arbitrary value.
   logic              clk = 1'b0, cclk = 1'b0, rst_n = 1'b0, chk = 1'b0, srv = 1'b0;
   logic              lv = 1'b0, rv = 1'b0, we = 1'b0, msk = 1'b0, cs = 1'b0, dop = 1'b0;
   logic signed [7:0] lt = 8'h00, rr = 8'h00, lh = 8'h55, ll = 8'hC0, rh = 8'h55, rl = 8'hC0;
   logic signed [7:0] lth = 8'h55, rth = 8'h55, off = 8'h00, el = 8'h00, er = 8'h00;
   logic [7:0]        hy = 8'h0A;
   logic [3:0]        dly = 4'h1;
   tat_pin_mode_t     pm = TAT_PIN_ALERT;
   logic              ara_rd, clr, ack, spoe, tsoe, sp, ts;
   logic [6:0]        aaddr, gaddr;
   logic [7:0]        st;
   logic signed [7:0] lvo, rvo;
   int                served, mismatches = 0, n_compared = 0;
   logic [25:0]       expq[$];
   logic [31:0]       rs = 32'h8;
   // ===
   // Clocks, design and host.
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      #3;
      forever #62.5 cclk = ~cclk;
   end
   tat_alert_thermal_shutdown_out #(.DEV_ADDR(ADDR)) uut (.sys_clk_in(clk), .rst_n_in(rst_n), .conv_clk_in(cclk),
      .conv_start_in(cs), .diode_open_in(dop), .local_valid_in(lv), .local_temp_in(lt),
      .remote_valid_in(rv), .remote_raw_in(rr), .cfg_we_in(we), .alert_mask_in(msk), .pin_mode_in(pm),
      .local_high_in(lh), .local_low_in(ll), .remote_high_in(rh), .remote_low_in(rl),
      .local_thermal_shutdown_out_in(lth), .remote_thermal_shutdown_out_in(rth), .hyst_in(hy), .offset_in(off), .status_clr_in(clr),
      .ara_read_in(ara_rd), .ara_addr_out(aaddr), .ara_ack_out(ack), .status_out(st),
      .local_value_out(lvo), .remote_value_out(rvo), .shared_pin_out(sp), .shared_pin_oe_out(spoe),
      .thermal_shutdown_out(ts), .thermal_shutdown_oe_out(tsoe));
   tat_host_model host (.clk_in(clk), .rst_n_in(rst_n), .en_in(srv), .dly_in(dly), .alert_low_in(spoe),
      .ara_ack_in(ack), .ara_addr_in(aaddr), .ara_read_out(ara_rd), .status_clr_out(clr),
      .addr_out(gaddr), .served_out(served));
   // ===
   // Tasks.
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [25:0] seen, input logic [25:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic expect_now(input logic t, input logic s, input logic [7:0] sv);
      expq.push_back({t, s, sv, el, er});
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
   endtask
   task automatic put(input logic rem, input logic signed [7:0] v);
      if (rem) begin
         rr <= v;
         rv <= 1'b1;
         er = v + off;
      end else begin
         lt <= v;
         lv <= 1'b1;
         el = v;
      end
      @(posedge clk);
      lv <= 1'b0;
      rv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic cfg();
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic serve();
      int s0;
      s0 = served;
      srv <= 1'b1;
      for (int i = 0; i < 60 && served == s0; i++) @(posedge clk);
      srv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ===
   // Monitor: each observation takes the oldest note.
   always @(posedge clk) begin
      if (chk) begin
         check({tsoe, spoe, st, lvo, rvo}, expq.pop_front());
         check({24'h0, sp, ts}, 26'h0);
      end
   end
   initial begin
      #200000;
      mismatches++;
      finish_test();
   end
   // ===
   // Scenarios.
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      expect_now(1'b0, 1'b0, 8'h00);
      // Low limits move below zero first, so empty channels do not trip the low compare.
      cfg();
      for (int i = 0; i < 4; i++) begin
         rs = xs(rs);
         put(rs[0], {2'b00, rs[13:8]} + 8'h0A);
         expect_now(1'b0, 1'b0, 8'h00);
      end
      lh <= el - 8'h01;
      cfg();
      expect_now(1'b0, 1'b1, 8'h02);
      lh <= 8'h55;
      cfg();
      serve();
      expect_now(1'b0, 1'b0, 8'h00);
      put(1'b0, 8'h56);
      expect_now(1'b1, 1'b1, 8'h02);
      put(1'b0, 8'h4C);
      expect_now(1'b1, 1'b1, 8'h02);
      put(1'b0, 8'h4B);
      expect_now(1'b0, 1'b1, 8'h02);
      dly <= 4'h6;
      serve();
      expect_now(1'b0, 1'b0, 8'h00);
      check({19'h0, gaddr}, {19'h0, ADDR});
      hy <= 8'h01;
      msk <= 1'b1;
      cfg();
      put(1'b0, 8'h56);
      expect_now(1'b1, 1'b0, 8'h02);
      put(1'b0, 8'h54);
      expect_now(1'b0, 1'b0, 8'h02);
      // Unmasking alone raises nothing: the alert latches on events, not on old status.
      msk <= 1'b0;
      cfg();
      expect_now(1'b0, 1'b0, 8'h02);
      put(1'b0, 8'h56);
      put(1'b0, 8'h54);
      expect_now(1'b0, 1'b1, 8'h02);
      dly <= 4'h1;
      serve();
      expect_now(1'b0, 1'b0, 8'h00);
      pm <= TAT_PIN_SECONDARY_THERMAL_OUT;
      msk <= 1'b1;
      off <= 8'hFC;
      cfg();
      put(1'b1, 8'h5A);
      expect_now(1'b1, 1'b1, 8'h10);
      put(1'b1, 8'h58);
      expect_now(1'b0, 1'b0, 8'h10);
      pm <= TAT_PIN_ALERT;
      msk <= 1'b0;
      off <= 8'h00;
      hy <= 8'h0A;
      cfg();
      expect_now(1'b0, 1'b0, 8'h10);
      dop <= 1'b1;
      repeat (3) @(posedge cclk);
      cs <= 1'b1;
      @(posedge cclk);
      cs <= 1'b0;
      dop <= 1'b0;
      repeat (8) @(posedge clk);
      expect_now(1'b0, 1'b1, 8'h14);
      serve();
      expect_now(1'b0, 1'b0, 8'h00);
      put(1'b0, 8'hC0);
      expect_now(1'b0, 1'b1, 8'h01);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule  // tat_alert_thermal_shutdown_out_tb
`default_nettype wire

// file: dv/tat_host_model.sv
// Host model that serves the alert line with an alert response read and a status clear.
`timescale 1ns/10ps
`default_nettype none
module tat_host_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       en_in,
   input  wire logic [3:0] dly_in,
   input  wire logic       alert_low_in,
   input  wire logic       ara_ack_in,
   input  wire logic [6:0] ara_addr_in,
   output logic            ara_read_out,
   output logic            status_clr_out,
   output logic [6:0]      addr_out,
   output var int          served_out
);
   // ===
   // Service loop; the delay input lets the bench answer promptly or slowly.
   initial begin
      ara_read_out = 1'b0;
      status_clr_out = 1'b0;
      addr_out = 7'h00;
      served_out = 0;
      forever begin
         @(posedge clk_in);
         if (rst_n_in && en_in && alert_low_in) begin
            repeat (dly_in) @(posedge clk_in);
            ara_read_out <= 1'b1;
            @(posedge clk_in);
            ara_read_out <= 1'b0;
            for (int i = 0; i < 8 && !ara_ack_in; i++) @(posedge clk_in);
            if (ara_ack_in) begin
               addr_out <= ara_addr_in;
               status_clr_out <= 1'b1;
               @(posedge clk_in);
               status_clr_out <= 1'b0;
               served_out <= served_out + 1;
            end
            // Let the alert settle so one event is not served twice.
            repeat (4) @(posedge clk_in);
         end
      end
   end
endmodule  // tat_host_model
`default_nettype wire

// file: pkg/tat_map.svh
// Constants for the temperature alert and thermal shutdown logic.
`ifndef TAT_MAP_SVH
`define TAT_MAP_SVH
`define TAT_THERMAL_SHUTDOWN_OUT_LIMIT_RST  8'h55
`define TAT_HYST_RST         8'h0A
`define TAT_HIGH_LIMIT_RST   8'h55
`define TAT_LOW_LIMIT_RST    8'h00
`define TAT_OFFSET_RST       8'h00
`define TAT_STAT_OPEN_BIT    2
`define TAT_STAT_LLOW_BIT    0
`define TAT_STAT_LHIGH_BIT   1
`define TAT_STAT_RLOW_BIT    3
`define TAT_STAT_RHIGH_BIT   4
`define TAT_ARA_ADDR         7'h0C
`endif

// file: pkg/tat_pkg.sv
// Types for the temperature alert and thermal shutdown logic.
package tat_pkg;
   typedef enum logic {TAT_PIN_ALERT, TAT_PIN_SECONDARY_THERMAL_OUT} tat_pin_mode_t;
endpackage

// file: rtl/tat_alert_thermal_shutdown_out.sv
// Alert, thermal shutdown and open-diode logic of a dual-channel temperature monitor.
`timescale 1ns/10ps
`default_nettype none
`include "tat_map.svh"

// Operation
// - Sample open-diode comparator at each conversion start; set status bit 2.
// - In alert mode the open-diode flag pulls alert low.
// - Alert low when a result exceeds high limit or is at/below low limit.
// - Alert is maskable; primary thermal output has no mask.
// - Alert releases after ARA read and status clear, if the cause ended.
// - Thermal output low when a result exceeds its thermal limit.
// - Thermal output releases by itself at limit minus hysteresis.
// - Both thermal limits reset to 85 degrees.
// - Hysteresis resets to 10 degrees, writable any time, shared by both channels.
// - Hysteresis is an unsigned count of whole degrees.
// - Shared pin acts as alert or as secondary thermal output.
// - Secondary thermal output trips on high limits, unmaskable, same hysteresis.
// - Signed offset is added to each remote result before storing and compare.
// - While alert is low, the ARA read returns this device address.
module tat_alert_thermal_shutdown_out
   import tat_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value.
) (
   input  wire logic                sys_clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                conv_clk_in,
   input  wire logic                conv_start_in,
   input  wire logic                diode_open_in,
   input  wire logic                local_valid_in,
   input  wire logic signed [7:0]   local_temp_in,
   input  wire logic                remote_valid_in,
   input  wire logic signed [7:0]   remote_raw_in,
   input  wire logic                cfg_we_in,
   input  wire logic                alert_mask_in,
   input  wire tat_pin_mode_t       pin_mode_in,
   input  wire logic signed [7:0]   local_high_in,
   input  wire logic signed [7:0]   local_low_in,
   input  wire logic signed [7:0]   remote_high_in,
   input  wire logic signed [7:0]   remote_low_in,
   input  wire logic signed [7:0]   local_thermal_shutdown_out_in,
   input  wire logic signed [7:0]   remote_thermal_shutdown_out_in,
   input  wire logic [7:0]          hyst_in,
   input  wire logic signed [7:0]   offset_in,
   input  wire logic                status_clr_in,
   input  wire logic                ara_read_in,
   output logic [6:0]               ara_addr_out,
   output logic                     ara_ack_out,
   output logic [7:0]               status_out,
   output logic signed [7:0]        local_value_out,
   output logic signed [7:0]        remote_value_out,
   output logic                     shared_pin_out,
   output logic                     shared_pin_oe_out,
   output logic                     thermal_shutdown_out,
   output logic                     thermal_shutdown_oe_out
);

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   logic signed [7:0] lhi_q, llo_q, rhi_q, rlo_q, lth_q, rth_q, off_q;
   logic [7:0]        hyst_q;
   logic              mask_q;
   tat_pin_mode_t     mode_q;
   logic              lim_wr_q;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lhi_q    <= `TAT_HIGH_LIMIT_RST;
         rhi_q    <= `TAT_HIGH_LIMIT_RST;
         llo_q    <= `TAT_LOW_LIMIT_RST;
         rlo_q    <= `TAT_LOW_LIMIT_RST;
         lth_q    <= `TAT_THERMAL_SHUTDOWN_OUT_LIMIT_RST;
         rth_q    <= `TAT_THERMAL_SHUTDOWN_OUT_LIMIT_RST;
         hyst_q   <= `TAT_HYST_RST;
         off_q    <= `TAT_OFFSET_RST;
         mask_q   <= 1'b0;
         mode_q   <= TAT_PIN_ALERT;
         lim_wr_q <= 1'b0;
      end else begin
         lim_wr_q <= cfg_we_in;
         if (cfg_we_in) begin
            lhi_q  <= local_high_in;
            llo_q  <= local_low_in;
            rhi_q  <= remote_high_in;
            rlo_q  <= remote_low_in;
            lth_q  <= local_thermal_shutdown_out_in;
            rth_q  <= remote_thermal_shutdown_out_in;
            hyst_q <= hyst_in;
            off_q  <= offset_in;
            mask_q <= alert_mask_in;
            mode_q <= pin_mode_in;
         end
      end
   end

   // ==========================================================================
   // Conversion clock domain: open-diode sampling
   // ==========================================================================
   // A toggle carries each fault event across, so no event is lost.
   logic c_open_s1_q, c_open_s2_q, c_tog_q;

   always_ff @(posedge conv_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_open_s1_q <= 1'b0;
         c_open_s2_q <= 1'b0;
         c_tog_q     <= 1'b0;
      end else begin
         c_open_s1_q <= diode_open_in;
         c_open_s2_q <= c_open_s1_q;
         if (conv_start_in && c_open_s2_q) begin
            c_tog_q <= ~c_tog_q;
         end
      end
   end

   logic t_s1_q, t_s2_q, t_s3_q;
   logic open_evt;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         t_s1_q <= 1'b0;
         t_s2_q <= 1'b0;
         t_s3_q <= 1'b0;
      end else begin
         t_s1_q <= c_tog_q;
         t_s2_q <= t_s1_q;
         t_s3_q <= t_s2_q;
      end
   end
   assign open_evt = t_s2_q ^ t_s3_q;

   // ==========================================================================
   // Results and comparisons
   // ==========================================================================
   logic signed [8:0] rsum;
   logic signed [7:0] rsat;
   logic              new_q;

   always_comb begin
      rsum = {remote_raw_in[7], remote_raw_in} + {off_q[7], off_q};
      if (rsum > 9'sd127) begin
         rsat = 8'sh7F;
      end else if (rsum < -9'sd128) begin
         rsat = 8'sh80;
      end else begin
         rsat = rsum[7:0];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         local_value_out  <= 8'sh00;
         remote_value_out <= 8'sh00;
         new_q            <= 1'b0;
      end else begin
         new_q <= local_valid_in | remote_valid_in;
         if (local_valid_in) begin
            local_value_out <= local_temp_in;
         end
         if (remote_valid_in) begin
            remote_value_out <= rsat;
         end
      end
   end

   logic eval;
   logic l_hi, l_lo, r_hi, r_lo, l_th, r_th, l_th_rel, r_th_rel, l_hi_rel, r_hi_rel;
   logic signed [9:0] hx;
   assign eval = new_q | lim_wr_q;
   assign hx   = {2'b00, hyst_q};

   always_comb begin
      l_hi     = local_value_out > lhi_q;
      r_hi     = remote_value_out > rhi_q;
      l_lo     = local_value_out <= llo_q;
      r_lo     = remote_value_out <= rlo_q;
      l_th     = local_value_out > lth_q;
      r_th     = remote_value_out > rth_q;
      l_th_rel = 10'(local_value_out) <= 10'(lth_q) - hx;
      r_th_rel = 10'(remote_value_out) <= 10'(rth_q) - hx;
      l_hi_rel = 10'(local_value_out) <= 10'(lhi_q) - hx;
      r_hi_rel = 10'(remote_value_out) <= 10'(rhi_q) - hx;
   end

   // ==========================================================================
   // Status register
   // ==========================================================================
   logic [7:0] st_set;

   always_comb begin
      st_set = 8'h00;
      st_set[`TAT_STAT_OPEN_BIT] = open_evt;
      st_set[`TAT_STAT_LHIGH_BIT] = eval & l_hi;
      st_set[`TAT_STAT_LLOW_BIT]  = eval & l_lo;
      st_set[`TAT_STAT_RHIGH_BIT] = eval & r_hi;
      st_set[`TAT_STAT_RLOW_BIT]  = eval & r_lo;
   end

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_out <= 8'h00;
      end else begin
         status_out <= (status_clr_in ? 8'h00 : status_out) | st_set;
      end
   end

   // ==========================================================================
   // Thermal outputs
   // ==========================================================================
   logic thermal_shutdown_out_q, secondary_thermal_out_q;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         thermal_shutdown_out_q  <= 1'b0;
         secondary_thermal_out_q <= 1'b0;
      end else if (eval) begin
         if (l_th || r_th) begin
            thermal_shutdown_out_q <= 1'b1;
         end else if (l_th_rel && r_th_rel) begin
            thermal_shutdown_out_q <= 1'b0;
         end
         if (l_hi || r_hi) begin
            secondary_thermal_out_q <= 1'b1;
         end else if (l_hi_rel && r_hi_rel) begin
            secondary_thermal_out_q <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Alert latch and alert response
   // ==========================================================================
   // Alert holds until serviced; the cause is judged from the live status bits.
   logic alert_q, served_q;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alert_q  <= 1'b0;
         served_q <= 1'b0;
      end else begin
         if (|st_set && !mask_q) begin
            alert_q  <= 1'b1;
            served_q <= 1'b0;
         end else if (alert_q) begin
            if (ara_read_in) begin
               served_q <= 1'b1;
            end
            if (served_q && status_out == 8'h00) begin
               alert_q  <= 1'b0;
               served_q <= 1'b0;
            end
         end
         if (mask_q) begin
            alert_q  <= 1'b0;
            served_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ara_addr_out <= 7'h00;
         ara_ack_out  <= 1'b0;
      end else begin
         ara_ack_out  <= ara_read_in && alert_q && mode_q == TAT_PIN_ALERT;
         ara_addr_out <= DEV_ADDR;
      end
   end

   always_comb begin
      thermal_shutdown_out    = 1'b0;
      thermal_shutdown_oe_out = thermal_shutdown_out_q;
      shared_pin_out          = 1'b0;
      shared_pin_oe_out       = 1'b0;
      unique case (mode_q)
         TAT_PIN_ALERT:  shared_pin_oe_out = alert_q;
         TAT_PIN_SECONDARY_THERMAL_OUT: shared_pin_oe_out = secondary_thermal_out_q;
      endcase
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   property p_thermal_shutdown_out_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         eval && (l_th || r_th) |=> thermal_shutdown_oe_out;
   endproperty
   a_thermal_shutdown_out_set: assert property (p_thermal_shutdown_out_set) else $error("thermal out not asserted");

   property p_thermal_shutdown_out_rel;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         eval && !l_th && !r_th && l_th_rel && r_th_rel |=> !thermal_shutdown_oe_out;
   endproperty
   a_thermal_shutdown_out_rel: assert property (p_thermal_shutdown_out_rel) else $error("thermal out not released");

   property p_alert_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         eval && (l_hi || r_lo) && !mask_q |=> alert_q;
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert not set");

   property p_open;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         open_evt |=> status_out[`TAT_STAT_OPEN_BIT];
   endproperty
   a_open: assert property (p_open) else $error("open flag not set");

   sequence s_unserved;
      !served_q;
   endsequence
   property p_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         (alert_q && !mask_q) and s_unserved |=> alert_q;
   endproperty
   a_hold: assert property (p_hold) else $error("alert released early");

   property p_mask;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         mask_q |=> !alert_q;
   endproperty
   a_mask: assert property (p_mask) else $error("masked alert asserted");

   property p_secondary_thermal_out;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         eval && l_hi && mode_q == TAT_PIN_SECONDARY_THERMAL_OUT ##1 mode_q == TAT_PIN_SECONDARY_THERMAL_OUT |-> shared_pin_oe_out;
   endproperty
   a_secondary_thermal_out: assert property (p_secondary_thermal_out) else $error("second thermal out not asserted");

   property p_offset;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         remote_valid_in && rsum == 9'(rsat) |=> remote_value_out == 8'($past(remote_raw_in) + $past(off_q));
   endproperty
   a_offset: assert property (p_offset) else $error("offset not applied");

endmodule  // tat_alert_thermal_shutdown_out
`default_nettype wire
